// File: core/uart_pkg.sv
/*
  Shared constants and types for the UART flow-control core: widths,
  bit positions of the control words, trigger tables, reset values and
  the serial state encoding.
  Assumes a single 10 MHz clock domain and no register bus.
*/
package uart_pkg;

  // Data path sizes
  localparam int DATA_W     = 8;
  localparam int ERR_W      = 3;
  localparam int FIFO_DEPTH = 64;
  localparam int LVL_W      = 7;
  localparam int DIV_W      = 16;
  localparam int GPIO_W     = 8;
  localparam int MS_W       = 4;

  // Oversampling: 16 ticks per bit, sampled at the middle tick
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Bit positions in the control words
  localparam int MCR_DTR  = 0;
  localparam int MCR_RTS  = 1;
  localparam int EFR_ARTS = 6;
  localparam int EFR_ACTS = 7;
  localparam int FCR_EN   = 0;
  localparam int IER_RXD  = 0;
  localparam int IER_TXS  = 1;
  localparam int IER_LSR  = 2;
  localparam int IER_MSR  = 3;

  // Modem lines shared with general purpose pins
  localparam int GP_DSR = 4;
  localparam int GP_DTR = 5;
  localparam int GP_CD  = 6;
  localparam int GP_RI  = 7;

  // Reset values and minimum divisor
  localparam logic             RTS_N_RST = 1'b1;
  localparam logic             IRQ_N_RST = 1'b1;
  localparam logic [DIV_W-1:0] DIV_MIN   = 16'h0001;

  // Trigger levels in characters
  localparam logic [LVL_W-1:0] TRIG_OFF      = 7'h01;
  localparam logic [LVL_W-1:0] FIFO_FULL_LVL = 7'h40;
  localparam logic [LVL_W-1:0] RX_TRIG_TAB   [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
  localparam logic [LVL_W-1:0] RX_RESUME_TAB [4] = '{7'h00, 7'h08, 7'h10, 7'h38};
  localparam logic [LVL_W-1:0] TX_TRIG_TAB   [4] = '{7'h08, 7'h10, 7'h20, 7'h38};

  // Serial engine states, one-hot
  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_START = 4'h2,
    S_DATA  = 4'h4,
    S_STOP  = 4'h8
  } ser_state_t;

endpackage

// File: core/fifo_if.sv
/*
  Carrier between the core and its FIFOs: fill side, drain side and level.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 8);
  import uart_pkg::*;
  logic [W-1:0]     wdata;
  logic             wvalid;
  logic             wready;
  logic [W-1:0]     rdata;
  logic             rvalid;
  logic             rready;
  logic [LVL_W-1:0] count;

  modport store (input wdata, wvalid, rready, output wready, rdata, rvalid, count);
  modport fill  (output wdata, wvalid, input wready);
  modport drain (input rdata, rvalid, count, output rready);
endinterface

// File: core/fifo_buf.sv
/*
  Synchronous FIFO with registered ready, valid and level.
  Assumes the drain side reads rdata in the cycle it raises rready.
*/
`timescale 1ns/1ps
module fifo_buf
  import uart_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  fifo_if.store     f
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          wready_q;
  logic          rvalid_q;

  // Handshakes and next level
  wire push = f.wvalid & wready_q;
  wire pop  = f.rready & rvalid_q;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  // Pointers and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q     <= '0;
      rp_q     <= '0;
      cnt_q    <= '0;
      wready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end else begin
      wp_q     <= wp_q + AW'(push);
      rp_q     <= rp_q + AW'(pop);
      cnt_q    <= cnt_d;
      wready_q <= cnt_d != (AW+1)'(DEPTH);
      rvalid_q <= cnt_d != '0;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_q] <= f.wdata;
    end
  end

  assign f.rdata  = mem[rp_q];
  assign f.wready = wready_q;
  assign f.rvalid = rvalid_q;
  assign f.count  = LVL_W'(cnt_q);

  a_fifo_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_q == (AW+1)'(DEPTH)) |-> !wready_q ##1 (cnt_q <= (AW+1)'(DEPTH)))
    else $error("fifo level passed its depth");
endmodule

// File: core/uart_flow_core.sv
/*
  UART core with 64-entry transmit and receive FIFOs, trigger levels,
  baud divider, automatic RTS/CTS flow control, modem/GPIO pins and an
  open-drain interrupt output.
  Assumes host-side control words and strobes come from logic on clk_i;
  serial and pin inputs are asynchronous and synchronised here.
*/
// Function
// - Interrupt output open-drain, active low, only for enabled sources
// - Sources: pin changes, line errors, receive data, transmit space, modem status
// - Modem control bit 1 set drives RTS pin low
// - RTS pin is high after any reset
// - RTS steers flow only when automatic RTS is enabled
// - Both FIFOs hold 64 characters; receive entries carry three error bits
// - Baud divider uses a 16-bit divisor from 1 to 65535
// - FIFOs disabled after reset, so trigger level is one character
// - Receive and transmit trigger levels set independently, selectable or programmed
// - Zero trigger level register selects FIFO control table levels
// - Auto CTS and auto RTS enabled separately by feature bits 7 and 6
// - Auto CTS: a character starts only while CTS is low
// - Auto RTS: asserted while receive FIFO has room, dropped when full enough
// - Zero transmission control register uses FIFO control trigger levels
// - Pins 4 to 7 are either general purpose or modem lines
// - CTS level readable as modem status bit 4
// - RTS drops at halt level bits 3:0, returns at resume bits 7:4
`timescale 1ns/1ps
module uart_flow_core
  import uart_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [DATA_W-1:0] tx_data_i,
  input  wire logic              tx_valid_i,
  output logic                   tx_ready_o,
  output logic [DATA_W-1:0]      rx_data_o,
  output logic [ERR_W-1:0]       rx_err_o,
  output logic                   rx_valid_o,
  input  wire logic              rx_ready_i,
  output logic [LVL_W-1:0]       tx_level_o,
  output logic [LVL_W-1:0]       rx_level_o,
  input  wire logic              rx_i,
  output logic                   tx_o,
  input  wire logic              cts_n_i,
  output logic                   rts_n_o,
  input  wire logic [7:0]        modem_control_reg_i,
  input  wire logic [7:0]        enhanced_feature_reg_i,
  input  wire logic [7:0]        fifo_control_reg_i,
  input  wire logic [7:0]        trigger_level_reg_i,
  input  wire logic [7:0]        transmission_control_reg_i,
  input  wire logic [7:0]        interrupt_enable_reg_i,
  input  wire logic [DIV_W-1:0]  divisor_i,
  input  wire logic [GPIO_W-1:0] io_dir_i,
  input  wire logic [GPIO_W-1:0] io_out_i,
  input  wire logic [GPIO_W-1:0] io_int_en_i,
  input  wire logic              io_modem_sel_i,
  input  wire logic              line_status_read_i,
  input  wire logic              modem_status_read_i,
  input  wire logic              io_state_read_i,
  output logic [ERR_W-1:0]       line_status_o,
  output logic [7:0]             modem_status_reg_o,
  output logic [GPIO_W-1:0]      io_state_o,
  output logic [GPIO_W-1:0]      io_change_o,
  input  wire logic [GPIO_W-1:0] gpio_i,
  output logic [GPIO_W-1:0]      gpio_o,
  output logic [GPIO_W-1:0]      gpio_oe_o,
  output logic                   interrupt_request_n_o,
  output logic                   interrupt_request_oe_o
);
  fifo_if #(.W(DATA_W))       txf ();
  fifo_if #(.W(DATA_W+ERR_W)) rxf ();

  // FIFOs, 64 deep each
  fifo_buf #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .f     (txf)
  );
  fifo_buf #(.W(DATA_W+ERR_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .f     (rxf)
  );

  // Pin synchronisers, two stages
  logic [GPIO_W+1:0] pin_m_q;
  logic [GPIO_W+1:0] pin_s_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_m_q <= '1;
      pin_s_q <= '1;
    end else begin
      pin_m_q <= {cts_n_i, rx_i, gpio_i};
      pin_s_q <= pin_m_q;
    end
  end
  wire              cts_s = pin_s_q[GPIO_W+1];
  wire              rx_s  = pin_s_q[GPIO_W];
  wire [GPIO_W-1:0] gp_s  = pin_s_q[GPIO_W-1:0];

  // Control decode
  wire fifo_en   = fifo_control_reg_i[FCR_EN];
  wire auto_cts  = enhanced_feature_reg_i[EFR_ACTS];
  wire auto_rts  = enhanced_feature_reg_i[EFR_ARTS];
  wire [LVL_W-1:0] rx_sel = RX_TRIG_TAB[fifo_control_reg_i[7:6]];
  wire [LVL_W-1:0] tx_sel = TX_TRIG_TAB[fifo_control_reg_i[5:4]];

  // Trigger levels: disabled FIFO means one, else programmed or table
  wire [LVL_W-1:0] rx_prog = {1'b0, trigger_level_reg_i[7:4], 2'b00};
  wire [LVL_W-1:0] tx_prog = {1'b0, trigger_level_reg_i[3:0], 2'b00};
  wire [LVL_W-1:0] rx_trig = !fifo_en ? TRIG_OFF : (rx_prog != '0 ? rx_prog : rx_sel);
  wire [LVL_W-1:0] tx_trig = !fifo_en ? TRIG_OFF : (tx_prog != '0 ? tx_prog : tx_sel);
  wire [LVL_W-1:0] tx_space = FIFO_FULL_LVL - txf.count;
  wire rx_avail = rxf.count >= rx_trig;
  wire tx_room  = tx_space >= tx_trig;

  // Flow thresholds: table levels when the control word is zero
  wire tcr_zero = transmission_control_reg_i == 8'h00;
  wire [LVL_W-1:0] halt_lvl = tcr_zero ? rx_sel
                              : {1'b0, transmission_control_reg_i[3:0], 2'b00};
  wire [LVL_W-1:0] resume_lvl = tcr_zero ? RX_RESUME_TAB[fifo_control_reg_i[7:6]]
                                : {1'b0, transmission_control_reg_i[7:4], 2'b00};

  // Baud tick generator, divisor of zero treated as one
  logic [DIV_W-1:0] div_q;
  logic             tick_q;
  wire [DIV_W-1:0]  div_eff = (divisor_i == '0) ? DIV_MIN : divisor_i;
  wire              div_hit = div_q >= (div_eff - DIV_MIN);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_hit ? '0 : div_q + DIV_MIN;
      tick_q <= div_hit;
    end
  end

  // Transmitter
  ser_state_t        tx_st_q;
  logic [DATA_W-1:0] tx_sh_q;
  logic [3:0]        tx_ovs_q;
  logic [2:0]        tx_bit_q;
  logic              tx_q;
  wire cts_ok  = !auto_cts || !cts_s;
  wire tx_pop  = (tx_st_q == S_IDLE) && txf.rvalid && cts_ok;
  wire tx_bend = tick_q && (tx_ovs_q == OVS_LAST);
  assign txf.rready = tx_pop;
  assign txf.wdata  = tx_data_i;
  assign txf.wvalid = tx_valid_i;

  // Bit timing counter runs only inside a character
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_st_q == S_IDLE) begin
      tx_ovs_q <= '0;
    end else if (tick_q) begin
      tx_ovs_q <= tx_ovs_q + 4'h1;
    end
  end

  // Character framing, CTS looked at only between characters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_q  <= S_IDLE;
      tx_sh_q  <= '0;
      tx_bit_q <= '0;
      tx_q     <= 1'b1;
    end else begin
      case (tx_st_q)
        S_IDLE: if (tx_pop) begin
          tx_sh_q <= txf.rdata;
          tx_q    <= 1'b0;
          tx_st_q <= S_START;
        end
        S_START: if (tx_bend) begin
          tx_q     <= tx_sh_q[0];
          tx_bit_q <= '0;
          tx_st_q  <= S_DATA;
        end
        S_DATA: if (tx_bend) begin
          tx_sh_q  <= tx_sh_q >> 1;
          tx_bit_q <= tx_bit_q + 3'h1;
          tx_q     <= (tx_bit_q == BIT_LAST) ? 1'b1 : tx_sh_q[1];
          tx_st_q  <= (tx_bit_q == BIT_LAST) ? S_STOP : S_DATA;
        end
        S_STOP: if (tx_bend) begin
          tx_st_q <= S_IDLE;
        end
        default: tx_st_q <= S_IDLE;
      endcase
    end
  end

  // Receiver, samples at the middle of each bit
  ser_state_t        rx_st_q;
  logic [DATA_W-1:0] rx_sh_q;
  logic [3:0]        rx_ovs_q;
  logic [2:0]        rx_bit_q;
  logic              rx_push_q;
  logic [ERR_W-1:0]  rx_err_q;
  logic              ovr_pend_q;
  wire rx_samp = tick_q && (rx_ovs_q == OVS_MID);
  assign rxf.wvalid = rx_push_q;
  assign rxf.wdata  = {rx_err_q, rx_sh_q};
  assign rxf.rready = rx_ready_i;

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_st_q == S_IDLE) begin
      rx_ovs_q <= '0;
    end else if (tick_q) begin
      rx_ovs_q <= rx_ovs_q + 4'h1;
    end
  end

  // Error bits per entry: break, framing, overrun
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_q   <= S_IDLE;
      rx_sh_q   <= '0;
      rx_bit_q  <= '0;
      rx_push_q <= 1'b0;
      rx_err_q  <= '0;
    end else begin
      rx_push_q <= 1'b0;
      case (rx_st_q)
        S_IDLE: if (!rx_s) begin
          rx_st_q <= S_START;
        end
        S_START: if (rx_samp) begin
          rx_bit_q <= '0;
          rx_st_q  <= rx_s ? S_IDLE : S_DATA;
        end
        S_DATA: if (rx_samp) begin
          rx_sh_q  <= {rx_s, rx_sh_q[DATA_W-1:1]};
          rx_bit_q <= rx_bit_q + 3'h1;
          rx_st_q  <= (rx_bit_q == BIT_LAST) ? S_STOP : S_DATA;
        end
        S_STOP: if (rx_samp) begin
          rx_err_q  <= {(rx_sh_q == '0) && !rx_s, !rx_s, ovr_pend_q};
          rx_push_q <= 1'b1;
          rx_st_q   <= S_IDLE;
        end
        default: rx_st_q <= S_IDLE;
      endcase
    end
  end

  // Overrun: a character lost to a full FIFO marks the next stored one
  wire ovr_set = rx_push_q && !rxf.wready;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_pend_q <= 1'b0;
    end else begin
      ovr_pend_q <= ovr_set || (ovr_pend_q && !(rx_push_q && rxf.wready));
    end
  end

  // Sticky line status, a new error beats a read in the same cycle
  logic [ERR_W-1:0] line_q;
  wire  [ERR_W-1:0] line_set = rx_push_q ? {rx_err_q[2:1], ovr_set} : '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_q <= '0;
    end else begin
      line_q <= line_set | (line_q & {ERR_W{!line_status_read_i}});
    end
  end

  // Auto RTS hysteresis: drop at halt level, return at resume level
  logic arts_on_q;
  logic rts_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arts_on_q <= 1'b1;
      rts_q     <= RTS_N_RST;
    end else begin
      arts_on_q <= (rxf.count >= halt_lvl) ? 1'b0
                   : (rxf.count <= resume_lvl) ? 1'b1 : arts_on_q;
      rts_q     <= auto_rts ? !arts_on_q : !modem_control_reg_i[MCR_RTS];
    end
  end

  // Modem status: high nibble live levels, low nibble sticky deltas
  wire [MS_W-1:0] ms_now = io_modem_sel_i ? {!gp_s[GP_CD], !gp_s[GP_RI], !gp_s[GP_DSR], !cts_s}
                                          : {3'h0, !cts_s};
  logic [MS_W-1:0] ms_hi_q;
  logic [MS_W-1:0] ms_dl_q;
  logic [GPIO_W-1:0] io_q;
  logic [GPIO_W-1:0] io_chg_q;
  logic [GPIO_W-1:0] gpo_q;
  logic [GPIO_W-1:0] gpoe_q;

  // Per-line deltas and per-pin GPIO behaviour
  generate
    for (genvar k = 0; k < MS_W; k++) begin : g_ms
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ms_hi_q[k] <= 1'b0;
          ms_dl_q[k] <= 1'b0;
        end else begin
          ms_hi_q[k] <= ms_now[k];
          ms_dl_q[k] <= (ms_now[k] ^ ms_hi_q[k]) || (ms_dl_q[k] && !modem_status_read_i);
        end
      end
    end
    for (genvar k = 0; k < GPIO_W; k++) begin : g_io
      wire modem_in  = io_modem_sel_i && (k == GP_DSR || k == GP_CD || k == GP_RI);
      wire modem_out = io_modem_sel_i && (k == GP_DTR);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          io_q[k]     <= 1'b1; // Matches synchroniser preset, no false change
          io_chg_q[k] <= 1'b0;
          gpo_q[k]    <= 1'b0;
          gpoe_q[k]   <= 1'b0;
        end else begin
          io_q[k]     <= gp_s[k];
          io_chg_q[k] <= ((gp_s[k] ^ io_q[k]) && !gpoe_q[k]) || (io_chg_q[k] && !io_state_read_i);
          gpo_q[k]    <= modem_out ? !modem_control_reg_i[MCR_DTR] : io_out_i[k];
          gpoe_q[k]   <= modem_out || (!modem_in && io_dir_i[k]);
        end
      end
    end
  endgenerate

  // CTS changes raise no interrupt while auto CTS runs the transmitter
  wire [MS_W-1:0] ms_irq = ms_dl_q & {3'h7, !auto_cts};
  wire irq_any = (interrupt_enable_reg_i[IER_RXD] && rx_avail)
              || (interrupt_enable_reg_i[IER_TXS] && tx_room)
              || (interrupt_enable_reg_i[IER_LSR] && (line_q != '0))
              || (interrupt_enable_reg_i[IER_MSR] && (ms_irq != '0))
              || ((io_chg_q & io_int_en_i) != '0);

  // Open-drain request: enable high only while pulling low
  logic irq_n_q;
  logic irq_oe_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_n_q  <= IRQ_N_RST;
      irq_oe_q <= 1'b0;
    end else begin
      irq_n_q  <= !irq_any;
      irq_oe_q <= irq_any;
    end
  end

  // Output wiring
  assign tx_ready_o             = txf.wready;
  assign rx_data_o              = rxf.rdata[DATA_W-1:0];
  assign rx_err_o               = rxf.rdata[DATA_W+ERR_W-1:DATA_W];
  assign rx_valid_o             = rxf.rvalid;
  assign tx_level_o             = txf.count;
  assign rx_level_o             = rxf.count;
  assign tx_o                   = tx_q;
  assign rts_n_o                = rts_q;
  assign line_status_o          = line_q;
  assign modem_status_reg_o     = {ms_hi_q, ms_dl_q};
  assign io_state_o             = io_q;
  assign io_change_o            = io_chg_q;
  assign gpio_o                 = gpo_q;
  assign gpio_oe_o              = gpoe_q;
  assign interrupt_request_n_o  = irq_n_q;
  assign interrupt_request_oe_o = irq_oe_q;

  // Checks
  sequence s_char_start;
    $fell(tx_q) && (tx_st_q == S_START);
  endsequence
  a_rts_reset_high: assert property (@(posedge clk_i) $fell(rst_i) |-> rts_n_o && !interrupt_request_oe_o)
    else $error("rts or irq not idle after reset");
  a_rts_manual: assert property (@(posedge clk_i) disable iff (rst_i)
    !auto_rts |=> rts_n_o == !$past(modem_control_reg_i[MCR_RTS]))
    else $error("rts does not follow modem control bit");
  a_cts_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    s_char_start |-> !$past(auto_cts) || !$past(cts_s))
    else $error("character started while cts high");
  a_cts_no_cut: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_st_q == S_DATA) && cts_s |=> tx_st_q != S_IDLE)
    else $error("character cut short");
  a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    (interrupt_enable_reg_i == 8'h00) && (io_int_en_i == '0) |=> interrupt_request_n_o)
    else $error("irq raised with all sources masked");
  a_irq_single: assert property (@(posedge clk_i) disable iff (rst_i)
    !fifo_en && (interrupt_enable_reg_i == 8'h01) && rxf.rvalid |=> !interrupt_request_n_o && interrupt_request_oe_o)
    else $error("one character did not raise irq");
  a_irq_prog: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_en && (rx_prog != '0) && (rxf.count < rx_prog) && (interrupt_enable_reg_i == 8'h01)
    |=> interrupt_request_n_o)
    else $error("programmed receive trigger ignored");
  a_rts_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    auto_rts && $stable(auto_rts) && (rxf.count >= halt_lvl) ##1 auto_rts |=> rts_n_o)
    else $error("rts still low at halt level");
  a_msr_cts: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> modem_status_reg_o[4] == !$past(cts_s))
    else $error("status bit 4 not cts level");
  a_baud_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_q && (div_eff == 16'h0002) && $stable(div_eff) |=> !tick_q ##1 tick_q)
    else $error("baud tick spacing wrong");
  a_gpio_modem: assert property (@(posedge clk_i) disable iff (rst_i)
    io_modem_sel_i |=> gpio_oe_o[GP_DTR] && !gpio_oe_o[GP_DSR] && !gpio_oe_o[GP_RI])
    else $error("modem pin direction wrong");
endmodule

// File: tb/remote_uart.sv
/*
  Far-end UART model: sends and collects 8N1 characters.
  Assumes divisor 1, so one bit lasts 16 clocks.
*/
`timescale 1ns/1ps
module remote_uart #(parameter int BIT_CLKS = 16) (
  input  wire logic clk_i,
  input  wire logic line_i,
  input  wire logic rts_n_i,
  output logic      line_o
);
  logic [7:0] rcv_q[$];
  logic [7:0] ch;
  initial line_o = 1'b1;
  // One character, held off while request-to-send is high
  task automatic send(input logic [7:0] c);
    logic [9:0] fr;
    fr = {1'b1, c, 1'b0};
    @(posedge clk_i);
    while (rts_n_i !== 1'b0) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      #1 line_o = fr[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
  endtask
  // Collector, sampling mid-bit
  initial forever begin
    @(negedge line_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      ch[i] = line_i;
    end
    repeat (BIT_CLKS) @(posedge clk_i);
    rcv_q.push_back(ch);
  end
endmodule

// File: tb/tb_top.sv
/*
  Self-checking bench for the UART flow-control core.
  Assumes the far-end model; GPIO direction, output and interrupt enables are tied.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
  import uart_pkg::*;
  logic             clk_i, rst_i, tx_valid, rx_ready, cts_n, rd_clr;
  logic [7:0]       tx_data, modem_control_reg, enhanced_feature_reg, fifo_control_reg, trigger_level_reg, transmission_control_reg, interrupt_enable_reg;
  logic             tx_ready, rx_valid, rts_n, tx_line, rx_line, irq_n, irq_oe;
  logic [7:0]       rx_data;
  logic [ERR_W-1:0] rx_err, lsr;
  logic             msel;
  logic [7:0]       gpi, modem_status_reg, gp_out, gp_oe, io_chg, io_st;
  logic [DIV_W-1:0] div;
  logic [LVL_W-1:0] tx_lvl, rx_lvl;
  int               num_errors, comparisons, cyc;
  uart_flow_core uut (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_err_o(rx_err), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .tx_level_o(tx_lvl), .rx_level_o(rx_lvl), .rx_i(rx_line), .tx_o(tx_line),
    .cts_n_i(cts_n), .rts_n_o(rts_n), .modem_control_reg_i(modem_control_reg), .enhanced_feature_reg_i(enhanced_feature_reg),
    .fifo_control_reg_i(fifo_control_reg), .trigger_level_reg_i(trigger_level_reg), .transmission_control_reg_i(transmission_control_reg),
    .interrupt_enable_reg_i(interrupt_enable_reg), .divisor_i(div), .io_dir_i(8'h00), .io_out_i(8'h00),
    .io_int_en_i(8'h00), .io_modem_sel_i(msel), .line_status_read_i(rd_clr),
    .modem_status_read_i(rd_clr), .io_state_read_i(rd_clr), .line_status_o(lsr), .modem_status_reg_o(modem_status_reg),
    .io_state_o(io_st), .io_change_o(io_chg), .gpio_i(gpi), .gpio_o(gp_out), .gpio_oe_o(gp_oe),
    .interrupt_request_n_o(irq_n), .interrupt_request_oe_o(irq_oe));
  remote_uart far (.clk_i(clk_i), .line_i(tx_line), .rts_n_i(rts_n), .line_o(rx_line));
  // Clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Leaves valid high so back-to-back pushes need no gap
  task automatic push(input logic [7:0] c);
    tx_data = c;
    tx_valid = 1'b1;
    for (int k = 0; k < 20 && tx_ready !== 1'b1; k++) step(1);
    step(1);
  endtask
  task automatic pop(input logic [7:0] e);
    for (int k = 0; k < 400 && rx_valid !== 1'b1; k++) step(1);
    `CHK("rx_data", e, rx_data)
    rx_ready = 1'b1;
    step(1);
    rx_ready = 1'b0;
    step(1);
  endtask
  task automatic t_reset;
    `CHK("rts_n", 1'b1, rts_n)
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("tx_o", 1'b1, tx_line)
    modem_control_reg = 8'h02;
    step(2);
    `CHK("rts_n manual", 1'b0, rts_n)
    $display("t_reset done");
  endtask
  task automatic t_cts;
    enhanced_feature_reg = 8'h80;
    push(8'hA5);
    tx_valid = 1'b0;
    step(300);
    `CHK("tx held", 1'b1, tx_line)
    cts_n = 1'b0;
    push(8'h5A);
    tx_valid = 1'b0;
    for (int k = 0; k < 400 && far.rcv_q.size() < 1; k++) step(1);
    for (int k = 0; k < 40 && tx_line !== 1'b0; k++) step(1);
    cts_n = 1'b1;
    for (int k = 0; k < 400 && far.rcv_q.size() < 2; k++) step(1);
    `CHK("first char", 8'hA5, far.rcv_q[0])
    `CHK("cut char", 8'h5A, far.rcv_q[1])
    $display("t_cts done");
  endtask
  task automatic t_fill;
    for (int i = 0; i < 64; i++) push(8'(i));
    tx_valid = 1'b0;
    step(2);
    `CHK("tx_level", 7'h40, tx_lvl)
    `CHK("tx_ready", 1'b0, tx_ready)
    cts_n = 1'b0;
    for (int k = 0; k < 12000 && far.rcv_q.size() < 66; k++) step(1);
    `CHK("drained", 7'h00, tx_lvl)
    `CHK("last char", 8'h3F, far.rcv_q[65])
    $display("t_fill done");
  endtask
  task automatic t_rx_irq;
    interrupt_enable_reg = 8'h01;
    far.send(8'hC3);
    for (int k = 0; k < 50 && rx_valid !== 1'b1; k++) step(1);
    step(2);
    `CHK("irq_n", 1'b0, irq_n)
    `CHK("irq_oe", 1'b1, irq_oe)
    `CHK("rx_err", 3'h0, rx_err)
    `CHK("line status", 3'h0, lsr)
    interrupt_enable_reg = 8'h00;
    step(2);
    `CHK("irq masked", 1'b1, irq_n)
    pop(8'hC3);
    $display("t_rx_irq done");
  endtask
  task automatic t_auto_rts;
    enhanced_feature_reg = 8'h40;
    modem_control_reg = 8'h00;
    fifo_control_reg = 8'h01;
    trigger_level_reg = 8'h10;
    transmission_control_reg = 8'h12;
    interrupt_enable_reg = 8'h01;
    step(3);
    `CHK("rts room", 1'b0, rts_n)
    for (int i = 0; i < 8; i++) far.send(8'h40 + 8'(i));
    step(5);
    `CHK("rts halt", 1'b1, rts_n)
    for (int i = 0; i < 3; i++) pop(8'h40 + 8'(i));
    step(3);
    `CHK("rts hold", 1'b1, rts_n)
    pop(8'h43);
    step(3);
    `CHK("rts resume", 1'b0, rts_n)
    `CHK("irq at 4", 1'b0, irq_n)
    pop(8'h44);
    step(2);
    `CHK("irq below", 1'b1, irq_n)
    for (int i = 5; i < 8; i++) pop(8'h40 + 8'(i));
    $display("t_auto_rts done");
  endtask
  // Modem pins, change flags, read clear and a divisor of two
  task automatic t_modem;
    msel = 1'b1;
    gpi = 8'hEF;
    step(4);
    `CHK("dsr level", 1'b1, modem_status_reg[5])
    `CHK("dsr change", 1'b1, modem_status_reg[1])
    `CHK("cts status", 1'b1, modem_status_reg[4])
    `CHK("dtr enable", 2'h2, gp_oe[5:4])
    `CHK("dtr level", 1'b1, gp_out[5])
    `CHK("pin state", 8'hEF, io_st)
    `CHK("pin change", 8'h10, io_chg)
    rd_clr = 1'b1;
    step(1);
    rd_clr = 1'b0;
    step(1);
    `CHK("change cleared", 8'h00, io_chg)
    `CHK("dsr cleared", 1'b0, modem_status_reg[1])
    div = 16'h0002;
    step(8);
    div = DIV_MIN;
    step(2);
    $display("t_modem done");
  endtask
  // Main sequence
  initial begin
    {tx_valid, rx_ready, rd_clr, cyc, num_errors, comparisons} = '0;
    cts_n = 1'b1;
    msel = 1'b0;
    gpi = 8'hFF;
    div = DIV_MIN;
    {tx_data, modem_control_reg, enhanced_feature_reg, fifo_control_reg, trigger_level_reg, transmission_control_reg, interrupt_enable_reg} = '0;
    rst_i = 1'b1;
    step(10);
    rst_i = 1'b0;
    rd_clr = 1'b1;
    step(1);
    rd_clr = 1'b0;
    t_reset();
    t_cts();
    t_fill();
    t_rx_irq();
    t_auto_rts();
    t_modem();
    close_out();
  end
endmodule
